// ===== bench/host_twi_model.sv
`timescale 1ns/1ps
module host_twi_model (
    // Clock
    input wire logic i_core_clk,
    // Two-wire pins
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    int nacks = 0;
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : wait_clk
    // Long phases: responder filters SCL by 3-4 clocks
    task automatic pulse(output logic s);
        wait_clk(10);
        o_scl = 1'b1;
        wait_clk(6);
        s = i_sda;
        wait_clk(6);
        o_scl = 1'b0;
        wait_clk(6);
    endtask : pulse
    task automatic start;
        o_sda_pull = 1'b0;
        wait_clk(6);
        o_scl = 1'b1;
        wait_clk(10);
        o_sda_pull = 1'b1;
        wait_clk(10);
        o_scl = 1'b0;
        wait_clk(6);
    endtask : start
    task automatic stop;
        o_sda_pull = 1'b1;
        wait_clk(6);
        o_scl = 1'b1;
        wait_clk(10);
        o_sda_pull = 1'b0;
        wait_clk(10);
    endtask : stop
    task automatic send(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            o_sda_pull = ~b[i];
            pulse(s);
        end
        o_sda_pull = 1'b0;
        pulse(s);
        if (s !== 1'b0) nacks++;
    endtask : send
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        start();
        send({thermal_ctrl_pkg::DEV_ADDR, 1'b0});
        send(addr);
        send(data);
        stop();
    endtask : wr
    // Single byte read, ended by NACK
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        logic s;
        start();
        send({thermal_ctrl_pkg::DEV_ADDR, 1'b0});
        send(addr);
        start();
        send({thermal_ctrl_pkg::DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) pulse(data[i]);
        o_sda_pull = 1'b0;
        pulse(s);
        stop();
    endtask : rd
endmodule : host_twi_model

// ===== bench/thermal_power_emulation_control_test.sv
`timescale 1ns/1ps
module thermal_power_emulation_control_test;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic rst_pin_n = 1'b1;
    logic ce = 1'b1;
    logic lp_pin = 1'b0;
    logic [15:0] temp = 16'h1900;
    logic scl, pull, sda_oe, sda_out, alert_n, pwm, h2w, h2p5w, lp_mode, stb;
    // Open-drain line: low while host pulls or device drives, else pull-up
    wire sda_line = ~pull & (sda_oe ? sda_out : 1'b1);
    logic [7:0] store_data;
    logic [7:0] val;
    logic [7:0] duty_tab [4] = '{8'h00, 8'h50, 8'hBF, 8'h3F};
    int n_errors = 0;
    int n_tests = 0;
    int n_store = 0;
    int cnt;
    initial forever #5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) if (stb === 1'b1) n_store++;
    thermal_power_emulation_control thermal_power_emulation_control_inst (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(ce),
        .i_module_reset_in_n(rst_pin_n), .i_low_power_request_pin(lp_pin), .o_host_alert_out_n(alert_n),
        .i_scl(scl), .i_sda(sda_line), .o_sda(sda_out), .o_sda_oe(sda_oe),
        .i_module_temp(temp), .i_supply_voltage(16'h8421), .i_nv_heater_value(8'hC5),
        .o_nv_store_stb(stb), .o_nv_store_data(store_data), .o_heater_pwm_1w(pwm),
        .o_heater_2w(h2w), .o_heater_2p5w(h2p5w), .o_low_power_mode(lp_mode)
    );
    host_twi_model host_twi_model_inst (
        .i_core_clk(i_core_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_pull(pull)
    );
    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : cyc
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_twi_model_inst.wr(a, d);
        cyc(4);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_twi_model_inst.rd(a, val);
        check(val, exp);
    endtask : rd_chk
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // Bus traffic is about 25k cycles
    initial begin
        repeat (90000) @(posedge i_core_clk);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end
    initial begin
        cyc(6);
        i_rst = 1'b0;
        cyc(10);
        check({h2w, h2p5w}, 2'b11);
        rd_chk(8'h62, 8'hC5);
        rd_chk(8'h1A, 8'h84);
        rd_chk(8'h1B, 8'h21);
        rd_chk(8'h16, 8'h19);
        rd_chk(8'h40, thermal_ctrl_pkg::READ_UNMAPPED);
        foreach (duty_tab[i]) begin
            wr(8'h62, duty_tab[i]);
            check(store_data, duty_tab[i]);
            cnt = 0;
            repeat (63) begin
                cyc(1);
                cnt += (pwm === 1'b1) ? 1 : 0;
            end
            check(16'(cnt), 16'(duty_tab[i][5:0]));
            check({h2p5w, h2w}, duty_tab[i][7:6]);
        end
        temp = 16'h4FFF;
        cyc(3);
        check(pwm, 1'b1);
        rd_chk(8'h17, 8'hFF);
        temp = 16'h5000;
        cyc(3);
        check(pwm, 1'b0);
        temp = 16'h4B01;
        cyc(5);
        check(pwm, 1'b0);
        temp = 16'h4B00;
        cyc(3);
        check(pwm, 1'b1);
        rd_chk(8'h62, 8'h3F);
        // Enable low: pin change must not reach the mode yet
        ce = 1'b0;
        lp_pin = 1'b1;
        cyc(8);
        check(lp_mode, 1'b0);
        ce = 1'b1;
        cyc(8);
        check({lp_mode, pwm}, 2'b10);
        wr(8'h62, 8'hC0);
        check({pwm, h2w, h2p5w}, 3'b000);
        wr(8'h7F, 8'h02);
        rd_chk(8'h7F, 8'h02);
        rd_chk(8'h92, 8'h01);
        lp_pin = 1'b0;
        cyc(8);
        rd_chk(8'h92, 8'h00);
        check({h2w, h2p5w}, 2'b11);
        wr(8'h5D, 8'h03);
        check({lp_mode, h2w}, 2'b10);
        rd_chk(8'h5D, 8'h03);
        wr(8'h5D, 8'h01);
        check(lp_mode, 1'b0);
        rd_chk(8'h91, 8'h01);
        wr(8'h93, 8'h00);
        check(alert_n, 1'b0);
        wr(8'h93, 8'h01);
        check(alert_n, 1'b1);
        rd_chk(8'h93, 8'h00);
        wr(8'h93, 8'h00);
        rst_pin_n = 1'b0;
        cyc(8);
        rd_chk(8'h91, 8'hFF);
        check(alert_n, 1'b1);
        rst_pin_n = 1'b1;
        cyc(8);
        check({h2w, h2p5w}, 2'b11);
        check(16'(n_store), 16'h0005);
        check(16'(host_twi_model_inst.nacks), 16'h0003);
        rd_chk(8'h5D, 8'h00);
        report_and_stop();
    end
endmodule : thermal_power_emulation_control_test

// ===== common/thermal_ctrl_pkg.sv
// Contract
// - Read/write heater register at address 98
// - Heater follows register only in high power
// - Low power mode switches every heater off
// - Heater setting kept in non-volatile store
// - Bits 0 to 5 set 1 W duty
// - Bits 6, 7 switch 2 W, 2.5 W
// - PWM off once temperature reaches 80 C
// - PWM restored at 5 C below cut-off
// - Supply voltage readable at addresses 26, 27
// - Page 2 address 145 shows reset pin
// - Page 2 address 146 shows low-power pin
// - Page 2 address 147 bit 0 drives alert
// - Low power from pin or override set
// - Temperature readable at addresses 22, 23
package thermal_ctrl_pkg;
    // Responder address on the two-wire bus (0xA0 write byte)
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    localparam logic [7:0] ADDR_TEMP_HIGH = 8'h16;
    localparam logic [7:0] ADDR_TEMP_LOW = 8'h17;
    localparam logic [7:0] ADDR_VOLT_HIGH = 8'h1A;
    localparam logic [7:0] ADDR_VOLT_LOW = 8'h1B;
    localparam logic [7:0] ADDR_POWER_MODE = 8'h5D;
    localparam logic [7:0] ADDR_HEATER = 8'h62;
    localparam logic [7:0] ADDR_PAGE_SELECT = 8'h7F;
    localparam logic [7:0] ADDR_RESET_PIN = 8'h91;
    localparam logic [7:0] ADDR_LP_PIN = 8'h92;
    localparam logic [7:0] ADDR_ALERT = 8'h93;
    localparam logic [7:0] PAGE_PINS = 8'h02;
    localparam int UPPER_BIT = 7;

    localparam int OVERRIDE_BIT = 0;
    localparam int POWER_SET_BIT = 1;
    localparam int ALERT_BIT = 0;
    localparam int SPOT_2W_BIT = 6;
    localparam int SPOT_2P5W_BIT = 7;
    localparam int DUTY_MSB = 5;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic ALERT_RESET = 1'b1;

    // PWM counts 0..62, so duty 63 stays on the whole period
    localparam logic [5:0] PWM_LAST = 6'h3E;

    // Temperature in 1/256 C steps, signed
    localparam int TEMP_SCALE = 256;
    localparam int CUTOFF_DEG_C = 80;
    localparam int HYST_DEG_C = 5;
    localparam logic signed [15:0] TEMP_CUTOFF = 16'(CUTOFF_DEG_C * TEMP_SCALE);
    localparam logic signed [15:0] TEMP_RESTORE = 16'((CUTOFF_DEG_C - HYST_DEG_C) * TEMP_SCALE);

    typedef enum logic [7:0] {
        RSP_IDLE = 8'h01,
        RSP_ADDR = 8'h02,
        RSP_ADDR_ACK = 8'h04,
        RSP_WR_BYTE = 8'h08,
        RSP_WR_ACK = 8'h10,
        RSP_RD_BYTE = 8'h20,
        RSP_RD_ACK = 8'h40,
        RSP_RD_NEXT = 8'h80
    } rsp_state_e;
endpackage : thermal_ctrl_pkg

// ===== hw/mgmt_responder.sv
`timescale 1ns/1ps
module mgmt_responder (
    // Clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_hold,
    // Two-wire pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // Register access
    output logic [7:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_stb,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data
);
    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic scl;
        logic sda;
        thermal_ctrl_pkg::rsp_state_e state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic rw;
        logic first;
        logic oe;
        logic [7:0] ptr;
        logic wr_stb;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } rsp_s;

    localparam rsp_s RSP_RESET = '{scl_sync: 3'h7, sda_sync: 3'h7, scl: 1'b1, sda: 1'b1,
        state: thermal_ctrl_pkg::RSP_IDLE, default: '0};

    rsp_s r_reg;
    rsp_s r_next;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    always_comb begin
        r_next = r_reg;
        r_next.wr_stb = 1'b0;
        r_next.scl_sync = {r_reg.scl_sync[1:0], i_scl};
        r_next.sda_sync = {r_reg.sda_sync[1:0], i_sda};
        // Level counts only once second and third stages agree
        if (r_reg.scl_sync[2] == r_reg.scl_sync[1]) begin
            r_next.scl = r_reg.scl_sync[2];
        end
        if (r_reg.sda_sync[2] == r_reg.sda_sync[1]) begin
            r_next.sda = r_reg.sda_sync[2];
        end
        scl_rise = !r_reg.scl && r_next.scl;
        scl_fall = r_reg.scl && !r_next.scl;
        start = r_reg.scl && r_next.scl && r_reg.sda && !r_next.sda;
        stop = r_reg.scl && r_next.scl && !r_reg.sda && r_next.sda;
        if (i_hold) begin
            // Pin reset: never drive, so reads float to all ones
            r_next = RSP_RESET;
        end else if (stop) begin
            r_next.state = thermal_ctrl_pkg::RSP_IDLE;
            r_next.oe = 1'b0;
        end else if (start) begin
            r_next.state = thermal_ctrl_pkg::RSP_ADDR;
            r_next.bit_cnt = '0;
            r_next.oe = 1'b0;
        end else begin
            unique case (r_reg.state)
                thermal_ctrl_pkg::RSP_IDLE: begin
                end
                thermal_ctrl_pkg::RSP_ADDR, thermal_ctrl_pkg::RSP_WR_BYTE: begin
                    if (scl_rise) begin
                        r_next.shift = {r_reg.shift[6:0], r_next.sda};
                        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    end else if (scl_fall && r_reg.bit_cnt == thermal_ctrl_pkg::BYTE_BITS) begin
                        r_next.oe = 1'b1;
                        if (r_reg.state == thermal_ctrl_pkg::RSP_ADDR) begin
                            r_next.rw = r_reg.shift[0];
                            r_next.state = thermal_ctrl_pkg::RSP_ADDR_ACK;
                            if (r_reg.shift[7:1] != thermal_ctrl_pkg::DEV_ADDR) begin
                                r_next.state = thermal_ctrl_pkg::RSP_IDLE;
                                r_next.oe = 1'b0;
                            end
                        end else begin
                            r_next.state = thermal_ctrl_pkg::RSP_WR_ACK;
                            if (r_reg.first) begin
                                r_next.ptr = r_reg.shift;
                                r_next.first = 1'b0;
                            end else begin
                                r_next.wr_stb = 1'b1;
                                r_next.wr_addr = r_reg.ptr;
                                r_next.wr_data = r_reg.shift;
                                r_next.ptr = r_reg.ptr + 8'h01;
                            end
                        end
                    end
                end
                thermal_ctrl_pkg::RSP_ADDR_ACK, thermal_ctrl_pkg::RSP_RD_NEXT: begin
                    if (scl_fall && r_reg.rw) begin
                        r_next.shift = i_rd_data;
                        r_next.oe = !i_rd_data[7];
                        r_next.bit_cnt = '0;
                        r_next.state = thermal_ctrl_pkg::RSP_RD_BYTE;
                    end else if (scl_fall) begin
                        r_next.first = 1'b1;
                        r_next.oe = 1'b0;
                        r_next.bit_cnt = '0;
                        r_next.state = thermal_ctrl_pkg::RSP_WR_BYTE;
                    end
                end
                thermal_ctrl_pkg::RSP_WR_ACK: begin
                    if (scl_fall) begin
                        r_next.oe = 1'b0;
                        r_next.bit_cnt = '0;
                        r_next.state = thermal_ctrl_pkg::RSP_WR_BYTE;
                    end
                end
                thermal_ctrl_pkg::RSP_RD_BYTE: begin
                    if (scl_fall && r_reg.bit_cnt == thermal_ctrl_pkg::LAST_BIT) begin
                        r_next.oe = 1'b0;
                        r_next.ptr = r_reg.ptr + 8'h01;
                        r_next.state = thermal_ctrl_pkg::RSP_RD_ACK;
                    end else if (scl_fall) begin
                        r_next.shift = {r_reg.shift[6:0], 1'b0};
                        r_next.oe = !r_reg.shift[6];
                        r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
                    end
                end
                thermal_ctrl_pkg::RSP_RD_ACK: begin
                    if (scl_rise) begin
                        r_next.state = r_next.sda ? thermal_ctrl_pkg::RSP_IDLE : thermal_ctrl_pkg::RSP_RD_NEXT;
                    end
                end
                default: begin
                    r_next.state = thermal_ctrl_pkg::RSP_IDLE;
                    r_next.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= RSP_RESET;
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    assign o_sda = 1'b0;
    assign o_sda_oe = r_reg.oe;
    assign o_rd_addr = r_reg.ptr;
    assign o_wr_stb = r_reg.wr_stb;
    assign o_wr_addr = r_reg.wr_addr;
    assign o_wr_data = r_reg.wr_data;

    chk_hold_release: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_hold && i_ce) |=> (!o_sda_oe && !o_wr_stb))
        else $error("responder drives bus while held in reset");
endmodule : mgmt_responder

// ===== hw/thermal_power_emulation_control.sv
`timescale 1ns/1ps
module thermal_power_emulation_control (
    // Clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Module pins
    input wire logic i_module_reset_in_n,
    input wire logic i_low_power_request_pin,
    output logic o_host_alert_out_n,
    // Two-wire management bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // Sensors
    input wire logic [15:0] i_module_temp,
    input wire logic [15:0] i_supply_voltage,
    // Non-volatile store
    input wire logic [7:0] i_nv_heater_value,
    output logic o_nv_store_stb,
    output logic [7:0] o_nv_store_data,
    // Heater spots and status
    output logic o_heater_pwm_1w,
    output logic o_heater_2w,
    output logic o_heater_2p5w,
    output logic o_low_power_mode
);
    typedef struct packed {
        logic [2:0] rst_sync;
        logic [2:0] lp_sync;
        logic rst_pin;
        logic lp_pin;
        logic nv_loaded;
        logic [7:0] heater;
        logic power_override;
        logic power_set;
        logic [7:0] page;
        logic alert;
        logic cutoff;
        logic [5:0] pwm_cnt;
        logic low_power;
        logic heat_pwm;
        logic heat_2w;
        logic heat_2p5w;
        logic nv_stb;
        logic [7:0] nv_data;
    } ctl_s;

    localparam ctl_s CTL_RESET = '{rst_sync: 3'h7, rst_pin: 1'b1, page: thermal_ctrl_pkg::PAGE_RESET,
        alert: thermal_ctrl_pkg::ALERT_RESET, low_power: 1'b1, default: '0};

    ctl_s r_reg;
    ctl_s r_next;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic heat_active;

    // Lower page always visible; upper half only on the pin page
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] page, input logic [7:0] target);
        addr_hit = (addr == target) && (!addr[thermal_ctrl_pkg::UPPER_BIT] || page == thermal_ctrl_pkg::PAGE_PINS);
    endfunction : addr_hit

    mgmt_responder u_responder (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_hold(!r_reg.rst_pin),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda(o_sda),
        .o_sda_oe(o_sda_oe),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data),
        .o_wr_stb(wr_stb),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data)
    );

    always_comb begin
        r_next = r_reg;
        r_next.nv_stb = 1'b0;
        r_next.rst_sync = {r_reg.rst_sync[1:0], i_module_reset_in_n};
        r_next.lp_sync = {r_reg.lp_sync[1:0], i_low_power_request_pin};
        if (r_reg.rst_sync[2] == r_reg.rst_sync[1]) begin
            r_next.rst_pin = r_reg.rst_sync[2];
        end
        if (r_reg.lp_sync[2] == r_reg.lp_sync[1]) begin
            r_next.lp_pin = r_reg.lp_sync[2];
        end
        if (!r_reg.nv_loaded) begin
            r_next.heater = i_nv_heater_value;
            r_next.nv_loaded = 1'b1;
        end
        if (wr_stb) begin
            if (addr_hit(wr_addr, r_reg.page, thermal_ctrl_pkg::ADDR_POWER_MODE)) begin
                r_next.power_override = wr_data[thermal_ctrl_pkg::OVERRIDE_BIT];
                r_next.power_set = wr_data[thermal_ctrl_pkg::POWER_SET_BIT];
            end
            // heater register write, mirrored to store
            if (addr_hit(wr_addr, r_reg.page, thermal_ctrl_pkg::ADDR_HEATER)) begin
                r_next.heater = wr_data;
                r_next.nv_stb = 1'b1;
                r_next.nv_data = wr_data;
            end
            if (addr_hit(wr_addr, r_reg.page, thermal_ctrl_pkg::ADDR_PAGE_SELECT)) begin
                r_next.page = wr_data;
            end
            if (addr_hit(wr_addr, r_reg.page, thermal_ctrl_pkg::ADDR_ALERT)) begin
                r_next.alert = wr_data[thermal_ctrl_pkg::ALERT_BIT];
            end
        end
        // Pin reset returns volatile settings to default
        if (!r_reg.rst_pin) begin
            r_next.power_override = 1'b0;
            r_next.power_set = 1'b0;
            r_next.page = thermal_ctrl_pkg::PAGE_RESET;
            r_next.alert = thermal_ctrl_pkg::ALERT_RESET;
        end
        r_next.low_power = r_reg.power_override ? r_reg.power_set : r_reg.lp_pin;
        if ($signed(i_module_temp) >= thermal_ctrl_pkg::TEMP_CUTOFF) begin
            r_next.cutoff = 1'b1;
        end else if ($signed(i_module_temp) <= thermal_ctrl_pkg::TEMP_RESTORE) begin
            r_next.cutoff = 1'b0;
        end
        r_next.pwm_cnt = (r_reg.pwm_cnt == thermal_ctrl_pkg::PWM_LAST) ? 6'h00 : r_reg.pwm_cnt + 6'h01;
        // heat only in high power, all off in low power
        heat_active = r_reg.nv_loaded && !r_reg.low_power;
        // duty field drives 1 W spot
        r_next.heat_pwm = heat_active && !r_reg.cutoff &&
            (r_reg.pwm_cnt < r_reg.heater[thermal_ctrl_pkg::DUTY_MSB:0]);
        r_next.heat_2w = heat_active && r_reg.heater[thermal_ctrl_pkg::SPOT_2W_BIT];
        r_next.heat_2p5w = heat_active && r_reg.heater[thermal_ctrl_pkg::SPOT_2P5W_BIT];
        // Read mux: temperature, voltage, pins
        rd_data = thermal_ctrl_pkg::READ_UNMAPPED;
        if (addr_hit(rd_addr, r_reg.page, thermal_ctrl_pkg::ADDR_TEMP_HIGH)) begin
            rd_data = i_module_temp[15:8];
        end else if (addr_hit(rd_addr, r_reg.page, thermal_ctrl_pkg::ADDR_TEMP_LOW)) begin
            rd_data = i_module_temp[7:0];
        end else if (addr_hit(rd_addr, r_reg.page, thermal_ctrl_pkg::ADDR_VOLT_HIGH)) begin
            rd_data = i_supply_voltage[15:8];
        end else if (addr_hit(rd_addr, r_reg.page, thermal_ctrl_pkg::ADDR_VOLT_LOW)) begin
            rd_data = i_supply_voltage[7:0];
        end else if (addr_hit(rd_addr, r_reg.page, thermal_ctrl_pkg::ADDR_POWER_MODE)) begin
            rd_data = {6'h00, r_reg.power_set, r_reg.power_override};
        end else if (addr_hit(rd_addr, r_reg.page, thermal_ctrl_pkg::ADDR_HEATER)) begin
            rd_data = r_reg.heater;
        end else if (addr_hit(rd_addr, r_reg.page, thermal_ctrl_pkg::ADDR_PAGE_SELECT)) begin
            rd_data = r_reg.page;
        end else if (addr_hit(rd_addr, r_reg.page, thermal_ctrl_pkg::ADDR_RESET_PIN)) begin
            rd_data = {7'h00, r_reg.rst_pin};
        end else if (addr_hit(rd_addr, r_reg.page, thermal_ctrl_pkg::ADDR_LP_PIN)) begin
            rd_data = {7'h00, r_reg.lp_pin};
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= CTL_RESET;
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    assign o_host_alert_out_n = r_reg.alert;
    assign o_nv_store_stb = r_reg.nv_stb;
    assign o_nv_store_data = r_reg.nv_data;
    assign o_heater_pwm_1w = r_reg.heat_pwm;
    assign o_heater_2w = r_reg.heat_2w;
    assign o_heater_2p5w = r_reg.heat_2p5w;
    assign o_low_power_mode = r_reg.low_power;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_heater_write;
        i_ce && wr_stb && addr_hit(wr_addr, r_reg.page, thermal_ctrl_pkg::ADDR_HEATER);
    endsequence
    sequence s_over_temp;
        i_ce && $signed(i_module_temp) >= thermal_ctrl_pkg::TEMP_CUTOFF;
    endsequence

    chk_low_power_off: assert property ((r_reg.low_power && i_ce) |=>
        (!o_heater_pwm_1w && !o_heater_2w && !o_heater_2p5w))
        else $error("heater on in low power mode");
    chk_cutoff_set: assert property (s_over_temp |=> r_reg.cutoff)
        else $error("cut-off not taken at limit");
    chk_cutoff_pwm: assert property (s_over_temp ##1 i_ce |=> !o_heater_pwm_1w)
        else $error("PWM spot on during cut-off");
    chk_cutoff_hold: assert property ((r_reg.cutoff && i_ce &&
        $signed(i_module_temp) > thermal_ctrl_pkg::TEMP_RESTORE) |=> r_reg.cutoff)
        else $error("cut-off released above restore level");
    chk_setting_kept: assert property ((r_reg.cutoff && r_reg.nv_loaded && !(wr_stb &&
        addr_hit(wr_addr, r_reg.page, thermal_ctrl_pkg::ADDR_HEATER))) |=> $stable(r_reg.heater))
        else $error("heater setting changed without a write");
    chk_nv_store: assert property (s_heater_write |=>
        (o_nv_store_stb && o_nv_store_data == $past(wr_data)))
        else $error("heater write not sent to store");
    chk_alert_drive: assert property ((i_ce && wr_stb &&
        addr_hit(wr_addr, r_reg.page, thermal_ctrl_pkg::ADDR_ALERT) && r_reg.rst_pin)
        |=> o_host_alert_out_n == $past(wr_data[thermal_ctrl_pkg::ALERT_BIT]))
        else $error("alert level not following write");
    chk_static_spots: assert property ((i_ce && r_reg.nv_loaded && !r_reg.low_power) |=>
        (o_heater_2w == $past(r_reg.heater[thermal_ctrl_pkg::SPOT_2W_BIT]) &&
        o_heater_2p5w == $past(r_reg.heater[thermal_ctrl_pkg::SPOT_2P5W_BIT])))
        else $error("static spot not following register");
    chk_pwm_full: assert property ((i_ce && r_reg.nv_loaded && !r_reg.low_power && !r_reg.cutoff &&
        (&r_reg.heater[thermal_ctrl_pkg::DUTY_MSB:0])) |=> o_heater_pwm_1w)
        else $error("full duty not fully on");
endmodule : thermal_power_emulation_control
